// ### twi_params.svh
// Constants of the two-wire slave
`ifndef TWI_PARAMS_SVH
`define TWI_PARAMS_SVH
`define TWI_ADDR_FIXED 2'h3
`define TWI_GCALL_ADDR 7'h00
`define TWI_BYTE_BITS 4'h8
`define TWI_MAX_BYTES 4'h8
`define TWI_SYNC_RESET 3'h7
`define TWI_FILT_LEN 2
`endif

// ### twi_pkg.sv
// Types shared by the two-wire slave modules
package twi_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_AACK = 3'b011,
      ST_RX = 3'b010,
      ST_RACK = 3'b110,
      ST_TX = 3'b111,
      ST_TACK = 3'b101
   } bus_state_e;
   typedef struct packed {
      logic start;
      logic stop;
      logic rise;
      logic fall;
      logic sda;
   } line_ev_s;
   typedef struct packed {
      logic [7:0] data;
      logic general;
      logic first;
   } rx_byte_s;
endpackage

// ### twi_line_sync.sv
// Pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
`include "twi_params.svh"
module twi_line_sync (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic pin_i,
   output logic level_o
);
   logic [2:0] sync_q;
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         sync_q <= `TWI_SYNC_RESET;
      end else if (ce_i) begin
         sync_q <= {sync_q[1:0], pin_i};
      end
   end
   // Only stages two and three are compared; a one-cycle spike never agrees
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         level_o <= 1'b1;
      end else if (ce_i && (sync_q[1] == sync_q[2])) begin
         level_o <= sync_q[2];
      end
   end
endmodule
`default_nettype wire

// ### twi_edge_detect.sv
// Start, stop and clock edge decoding
`timescale 1ns/1ns
`default_nettype none
module twi_edge_detect
   import twi_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output twi_pkg::line_ev_s ev_o
);
   logic scl_q;
   logic sda_q;
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else if (ce_i) begin
         scl_q <= scl_i;
         sda_q <= sda_i;
      end
   end
   always_comb begin
      ev_o.sda = sda_i;
      ev_o.rise = scl_i & ~scl_q;
      ev_o.fall = ~scl_i & scl_q;
      ev_o.start = scl_i & scl_q & sda_q & ~sda_i;
      ev_o.stop = scl_i & scl_q & ~sda_q & sda_i;
   end
endmodule
`default_nettype wire

// ### twi_slave.sv
// Two-wire bus slave of the motor driver
//
// Behaviour
// - Data sampled only while clock high
// - Start and stop decoded with clock high
// - Busy from start to stop; restart same
// - Eight bits per byte, msb first
// - Release after byte; receiver pulls low
// - Slave may stretch clock when not ready
// - Unmatched address leaves data high
// - Refuse further data by not acknowledging
// - Master nack ends read; slave releases
// - First byte: address then direction bit
// - Direction zero write, one read
// - Compare address, pick receive or transmit
// - Address: fixed ones, nonvolatile, strap
// - Sample data on rising clock edge
// - Write keeps one direction to stop
// - Read uses retained register pointer
// - Any start resets the bus machine
// - Acknowledge general call address
// - Drive lines low or release only
// - Address byte bit layout
// - Spikes on data suppressed
`timescale 1ns/1ns
`default_nettype none
`include "twi_params.svh"
module twi_slave
   import twi_pkg::*;
#(
   parameter int MAX_BYTES = `TWI_MAX_BYTES
) (
   input wire logic CLK_I,
   input wire logic RST_B_I,
   input wire logic CE_I,
   input wire logic SCL_LINK_I,
   input wire logic SCL_I,
   input wire logic SDA_I,
   output logic SCL_O,
   output logic SCL_OE_O,
   output logic SDA_O,
   output logic SDA_OE_O,
   input wire logic [3:0] PROGRAMMED_ADDRESS_FIELD_I,
   input wire logic STRAP_ADDRESS_BIT_I,
   input wire logic RX_READY_I,
   input wire logic [7:0] TX_DATA_I,
   output twi_pkg::rx_byte_s RX_BYTE_O,
   output logic RX_VALID_O,
   output logic [7:0] POINTER_O,
   output logic TX_REQ_O,
   output logic BUSY_O
);
   import twi_pkg::*;

   if (MAX_BYTES < 1 || MAX_BYTES > 15) begin : g_max_check
      $error("MAX_BYTES out of range");
   end

   // -----------------------------------------------------------------
   // Link-clock domain: toggles on each rising bus clock edge; its synchronised copy is masked to zero at BUSY_O
   // -----------------------------------------------------------------
   logic link_tog_q;
   always_ff @(posedge SCL_LINK_I) begin
      if (!RST_B_I) begin
         link_tog_q <= 1'b0;
      end else begin
         link_tog_q <= ~link_tog_q;
      end
   end

   // -----------------------------------------------------------------
   // Pin synchronisation
   // -----------------------------------------------------------------
   logic scl_s;
   logic sda_s;
   logic tog_s;
   line_ev_s ev;
   twi_line_sync u_scl_sync (
      .clk_i(CLK_I),
      .rst_b_i(RST_B_I),
      .ce_i(CE_I),
      .pin_i(SCL_I),
      .level_o(scl_s)
   );
   twi_line_sync u_sda_sync (
      .clk_i(CLK_I),
      .rst_b_i(RST_B_I),
      .ce_i(CE_I),
      .pin_i(SDA_I),
      .level_o(sda_s)
   );
   twi_line_sync u_tog_sync (
      .clk_i(CLK_I),
      .rst_b_i(RST_B_I),
      .ce_i(CE_I),
      .pin_i(link_tog_q),
      .level_o(tog_s)
   );
   twi_edge_detect u_edge (
      .clk_i(CLK_I),
      .rst_b_i(RST_B_I),
      .ce_i(CE_I),
      .scl_i(scl_s),
      .sda_i(sda_s),
      .ev_o(ev)
   );

   // -----------------------------------------------------------------
   // Address
   // -----------------------------------------------------------------
   // Strap is caught after reset release, never under reset
   logic strap_q;
   logic strap_done_q;
   always_ff @(posedge CLK_I) begin
      if (!RST_B_I) begin
         strap_q <= 1'b0;
         strap_done_q <= 1'b0;
      end else if (CE_I && !strap_done_q) begin
         strap_q <= STRAP_ADDRESS_BIT_I;
         strap_done_q <= 1'b1;
      end
   end
   logic [6:0] own_addr;
   assign own_addr = {`TWI_ADDR_FIXED, PROGRAMMED_ADDRESS_FIELD_I, strap_q};

   function automatic logic addr_hit(input logic [6:0] a, input logic [6:0] own);
      addr_hit = (a == own) || (a == `TWI_GCALL_ADDR);
   endfunction

   // -----------------------------------------------------------------
   // Bus state machine
   // -----------------------------------------------------------------
   bus_state_e state_q;
   logic [3:0] bit_q;
   logic [7:0] shift_q;
   logic [3:0] nbytes_q;
   logic read_q;
   logic gcall_q;
   logic first_q;
   logic refuse_q;
   logic busy_q;
   logic sda_hold_q;
   logic stretch_q;
   logic [7:0] tx_q;
   logic master_ack_q;

   always_ff @(posedge CLK_I) begin
      if (!RST_B_I) begin
         busy_q <= 1'b0;
      end else if (CE_I) begin
         if (ev.start) begin
            busy_q <= 1'b1;
         end else if (ev.stop) begin
            busy_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RST_B_I) begin
         state_q <= ST_IDLE;
         bit_q <= 4'h0;
         shift_q <= 8'h00;
         nbytes_q <= 4'h0;
         read_q <= 1'b0;
         gcall_q <= 1'b0;
         first_q <= 1'b0;
         refuse_q <= 1'b0;
         master_ack_q <= 1'b0;
      end else if (CE_I) begin
         if (ev.start) begin
            state_q <= ST_ADDR;
            bit_q <= 4'h0;
            nbytes_q <= 4'h0;
            refuse_q <= 1'b0;
         end else if (ev.stop) begin
            state_q <= ST_IDLE;
         end else begin
            case (state_q)
               ST_ADDR, ST_RX: begin
                  if (ev.rise) begin
                     shift_q <= {shift_q[6:0], ev.sda};
                     bit_q <= bit_q + 4'h1;
                  end else if (ev.fall && bit_q == `TWI_BYTE_BITS) begin
                     bit_q <= 4'h0;
                     if (state_q == ST_ADDR) begin
                        if (addr_hit(shift_q[7:1], own_addr)) begin
                           read_q <= shift_q[0];
                           gcall_q <= (shift_q[7:1] == `TWI_GCALL_ADDR);
                           first_q <= 1'b1;
                           state_q <= ST_AACK;
                        end else begin
                           state_q <= ST_IDLE;
                        end
                     end else begin
                        // Refuse when full or not ready
                        refuse_q <= (nbytes_q >= 4'(MAX_BYTES)) || !RX_READY_I;
                        state_q <= ST_RACK;
                     end
                  end
               end
               ST_AACK: begin
                  if (ev.fall) begin
                     state_q <= read_q ? ST_TX : ST_RX;
                  end
               end
               ST_RACK: begin
                  if (ev.fall) begin
                     first_q <= 1'b0;
                     nbytes_q <= nbytes_q + 4'h1;
                     state_q <= refuse_q ? ST_IDLE : ST_RX;
                  end
               end
               ST_TX: begin
                  if (ev.rise) begin
                     bit_q <= bit_q + 4'h1;
                  end else if (ev.fall && bit_q == `TWI_BYTE_BITS) begin
                     bit_q <= 4'h0;
                     state_q <= ST_TACK;
                  end
               end
               ST_TACK: begin
                  if (ev.rise) begin
                     master_ack_q <= ~ev.sda;
                  end else if (ev.fall) begin
                     state_q <= master_ack_q ? ST_TX : ST_IDLE;
                  end
               end
               default: begin
                  state_q <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // -----------------------------------------------------------------
   // Transmit byte and pointer
   // -----------------------------------------------------------------
   always_ff @(posedge CLK_I) begin
      if (!RST_B_I) begin
         tx_q <= 8'hFF;
         POINTER_O <= 8'h00;
         TX_REQ_O <= 1'b0;
      end else if (CE_I) begin
         TX_REQ_O <= 1'b0;
         if ((state_q == ST_AACK && read_q && ev.fall) ||
             (state_q == ST_TACK && master_ack_q && ev.fall)) begin
            tx_q <= TX_DATA_I;
            TX_REQ_O <= 1'b1;
         end else if (state_q == ST_TX && ev.fall) begin
            tx_q <= {tx_q[6:0], 1'b1};
         end
         if (state_q == ST_RACK && ev.fall && first_q && !gcall_q && !refuse_q) begin
            POINTER_O <= shift_q;
         end
      end
   end

   // -----------------------------------------------------------------
   // Received bytes
   // -----------------------------------------------------------------
   always_ff @(posedge CLK_I) begin
      if (!RST_B_I) begin
         RX_BYTE_O <= '0;
         RX_VALID_O <= 1'b0;
      end else if (CE_I) begin
         RX_VALID_O <= 1'b0;
         // General call byte delivered as action
         if (state_q == ST_RACK && ev.fall && !refuse_q) begin
            RX_BYTE_O <= '{data: shift_q, general: gcall_q, first: first_q};
            RX_VALID_O <= 1'b1;
         end
      end
   end

   // -----------------------------------------------------------------
   // Line drivers
   // -----------------------------------------------------------------
   always_ff @(posedge CLK_I) begin
      if (!RST_B_I) begin
         sda_hold_q <= 1'b0;
      end else if (CE_I) begin
         // Ack low, data driven in clock low
         if (ev.start || ev.stop) begin
            sda_hold_q <= 1'b0;
         end else if (ev.fall) begin
            if (state_q == ST_ADDR && bit_q == `TWI_BYTE_BITS) begin
               sda_hold_q <= addr_hit(shift_q[7:1], own_addr);
            end else if (state_q == ST_RX && bit_q == `TWI_BYTE_BITS) begin
               sda_hold_q <= (nbytes_q < 4'(MAX_BYTES)) && RX_READY_I;
            end else if (state_q == ST_AACK && read_q) begin
               sda_hold_q <= ~TX_DATA_I[7];
            end else if (state_q == ST_TACK && master_ack_q) begin
               sda_hold_q <= ~TX_DATA_I[7];
            end else if (state_q == ST_TX && bit_q != `TWI_BYTE_BITS) begin
               sda_hold_q <= ~tx_q[6];
            end else begin
               sda_hold_q <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RST_B_I) begin
         stretch_q <= 1'b0;
      end else if (CE_I) begin
         // Hold clock low while not ready
         if (ev.start || ev.stop) begin
            stretch_q <= 1'b0;
         end else if (ev.fall && state_q == ST_RACK && !refuse_q) begin
            stretch_q <= !RX_READY_I;
         end else if (stretch_q && RX_READY_I) begin
            stretch_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RST_B_I) begin
         SDA_O <= 1'b0;
         SDA_OE_O <= 1'b0;
         SCL_O <= 1'b0;
         SCL_OE_O <= 1'b0;
         BUSY_O <= 1'b0;
      end else if (CE_I) begin
         SDA_O <= 1'b0;
         SCL_O <= 1'b0;
         SDA_OE_O <= sda_hold_q;
         SCL_OE_O <= stretch_q;
         BUSY_O <= busy_q | (tog_s & 1'b0);
      end
   end
endmodule
`default_nettype wire

// ### twi_slave_monitor.sv
// Protocol checker for the two-wire slave pins
`timescale 1ns/1ns
`default_nettype none
module twi_slave_monitor (
   input wire logic CLK_I,
   input wire logic RST_B_I,
   input wire logic SCL_I,
   input wire logic SDA_I,
   input wire logic SCL_O,
   input wire logic SDA_O,
   input wire logic SCL_OE_O,
   input wire logic SDA_OE_O,
   input wire logic RX_READY_I,
   input wire logic RX_VALID_O,
   input wire logic TX_REQ_O,
   input wire logic BUSY_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RST_B_I);
   // ------------------------------------------------------------
   // Pin checks
   // ------------------------------------------------------------
   drive_low_a: assert property (!SCL_O && !SDA_O)
      else $error("line driven high");
   rx_pulse_a: assert property (RX_VALID_O |=> !RX_VALID_O)
      else $error("rx valid too long");
   tx_pulse_a: assert property (TX_REQ_O |=> !TX_REQ_O)
      else $error("tx request too long");
   idle_quiet_a: assert property (!BUSY_O |-> !SDA_OE_O && !SCL_OE_O)
      else $error("drive while bus free");
   // Window covers three sync flops, filter and edge stage
   start_busy_a: assert property ($fell(SDA_I) && SCL_I |-> ##[3:8] BUSY_O)
      else $error("start not seen");
   stop_free_a: assert property ($rose(SDA_I) && SCL_I |-> ##[3:8] !BUSY_O)
      else $error("stop not seen");
   data_steady_a: assert property ($changed(SDA_OE_O) |-> !SCL_I)
      else $error("data moved with clock high");
   stretch_hold_a: assert property (SCL_OE_O && !RX_READY_I |=> SCL_OE_O)
      else $error("stretch dropped early");
   stretch_end_a: assert property (SCL_OE_O && RX_READY_I |-> ##[1:4] !SCL_OE_O)
      else $error("stretch not released");
endmodule
`default_nettype wire

// ### twi_master_model.sv
// Bus master model pulling the open-drain lines
`timescale 1ns/1ns
`default_nettype none
module twi_master_model (
   input wire logic clk_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_low_o,
   output logic sda_low_o
);
   // ------------------------------------------------------------
   // Bit timing
   // ------------------------------------------------------------
   // Third of a bit, 25 cycles, stays well clear of the sync delay
   task automatic q();
      repeat (25) @(negedge clk_i);
   endtask
   task automatic rel_scl();
      scl_low_o = 1'b0;
      @(negedge clk_i);
      wait (scl_i === 1'b1);
      q();
   endtask
   task automatic start();
      sda_low_o = 1'b0;
      q();
      rel_scl();
      sda_low_o = 1'b1;
      q();
      scl_low_o = 1'b1;
      q();
   endtask
   task automatic stop();
      sda_low_o = 1'b1;
      q();
      rel_scl();
      sda_low_o = 1'b0;
      q();
   endtask
   task automatic xfer(input logic b, output logic r);
      sda_low_o = !b;
      q();
      rel_scl();
      r = sda_i;
      scl_low_o = 1'b1;
      q();
   endtask
   task automatic wr(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) xfer(d[i], r);
      xfer(1'b1, r);
      ack = !r;
   endtask
   task automatic rd(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
      xfer(last, r);
   endtask
   initial begin
      scl_low_o = 1'b0;
      sda_low_o = 1'b0;
   end
endmodule
`default_nettype wire

// ### test_twi_slave.sv
// Self-checking bench for the two-wire slave
`timescale 1ns/1ns
`default_nettype none
module test_twi_slave;
   import twi_pkg::*;
   // ------------------------------------------------------------
   // Bench signals
   // ------------------------------------------------------------
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic rx_ready = 1'b1;
   logic [7:0] tx_data = 8'h00;
   logic [3:0] paf = 4'hA;
   logic strap = 1'b1;
   logic stretched = 1'b0;
   logic scl_oe, sda_oe, m_scl, m_sda, rx_valid, tx_req, busy, ack;
   logic [7:0] pointer, rd;
   rx_byte_s rx_byte, last_rx;
   int n_errors = 0;
   int num_checks = 0;
   // Own address 1_1_1010_1 with write bit
   localparam logic [7:0] ADR_W = 8'hEB & 8'hFE;
   wire logic scl = !(scl_oe || m_scl);
   wire logic sda = !(sda_oe || m_sda);
   twi_slave #(.MAX_BYTES(8)) uut (
      .CLK_I(clk), .RST_B_I(rst_b), .CE_I(1'b1), .SCL_LINK_I(scl), .SCL_I(scl),
      .SDA_I(sda), .SCL_O(), .SCL_OE_O(scl_oe), .SDA_O(), .SDA_OE_O(sda_oe),
      .PROGRAMMED_ADDRESS_FIELD_I(paf), .STRAP_ADDRESS_BIT_I(strap),
      .RX_READY_I(rx_ready), .TX_DATA_I(tx_data), .RX_BYTE_O(rx_byte),
      .RX_VALID_O(rx_valid), .POINTER_O(pointer), .TX_REQ_O(tx_req), .BUSY_O(busy));
   twi_master_model m (
      .clk_i(clk), .scl_i(scl), .sda_i(sda), .scl_low_o(m_scl), .sda_low_o(m_sda));
   always #5 clk = ~clk;
   always @(posedge clk) begin
      if (rx_valid === 1'b1) last_rx <= rx_byte;
      if (scl_oe === 1'b1) stretched <= 1'b1;
   end
   task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic summarize();
      if (n_errors == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic open_w();
      m.start();
      m.wr(ADR_W, ack);
      chk("addr ack", {7'h0, ack}, 8'h01);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // Frames stay within eight bytes
   task automatic t_write();
      open_w();
      m.wr(8'h5C, ack);
      chk("ptr ack", {7'h0, ack}, 8'h01);
      m.wr(8'hA3, ack);
      chk("data", last_rx.data, 8'hA3);
      chk("first flag", {7'h0, last_rx.first}, 8'h00);
      m.stop();
      repeat (10) @(negedge clk);
      chk("busy", {7'h0, busy}, 8'h00);
      chk("pointer", pointer, 8'h5C);
   endtask
   task automatic t_wrong();
      m.start();
      m.wr(8'hE2, ack);
      chk("foreign ack", {7'h0, ack}, 8'h00);
      chk("busy held", {7'h0, busy}, 8'h01);
      m.stop();
   endtask
   task automatic t_read();
      open_w();
      m.wr(8'h33, ack);
      tx_data = 8'hC5;
      m.start();
      m.wr(ADR_W | 8'h01, ack);
      chk("read ack", {7'h0, ack}, 8'h01);
      m.rd(1'b1, rd);
      chk("read data", rd, 8'hC5);
      m.stop();
      chk("pointer", pointer, 8'h33);
   endtask
   task automatic t_gcall();
      m.start();
      m.wr(8'h00, ack);
      chk("gcall ack", {7'h0, ack}, 8'h01);
      m.wr(8'h06, ack);
      chk("gcall data", last_rx.data, 8'h06);
      chk("gcall flag", {7'h0, last_rx.general}, 8'h01);
      m.stop();
      chk("pointer", pointer, 8'h33);
   endtask
   task automatic t_restart();
      open_w();
      m.xfer(1'b1, ack);
      m.xfer(1'b0, ack);
      m.xfer(1'b1, ack);
      open_w();
      m.wr(8'h77, ack);
      m.stop();
      chk("pointer", pointer, 8'h77);
   endtask
   // Ready drops during the ack, so the next bit must wait
   task automatic t_stretch();
      open_w();
      fork
         begin
            wait (sda_oe === 1'b1);
            @(negedge clk);
            rx_ready = 1'b0;
            repeat (1000) @(negedge clk);
            rx_ready = 1'b1;
         end
         begin
            m.wr(8'h11, ack);
            chk("stretch ack", {7'h0, ack}, 8'h01);
            m.wr(8'h22, ack);
            chk("late ack", {7'h0, ack}, 8'h01);
         end
      join
      rx_ready = 1'b0;
      m.wr(8'h44, ack);
      chk("refuse ack", {7'h0, ack}, 8'h00);
      rx_ready = 1'b1;
      m.stop();
      chk("stretch", {7'h0, stretched}, 8'h01);
   endtask
   initial begin
      repeat (3) @(negedge clk);
      rst_b = 1'b1;
      repeat (4) @(negedge clk);
      t_write();
      t_wrong();
      t_read();
      t_gcall();
      t_restart();
      t_stretch();
      summarize();
   end
   // Whole run needs about 14000 cycles
   initial begin
      repeat (60000) @(posedge clk);
      n_errors++;
      summarize();
   end
endmodule
bind twi_slave twi_slave_monitor mon (
   .CLK_I(CLK_I), .RST_B_I(RST_B_I), .SCL_I(SCL_I), .SDA_I(SDA_I), .SCL_O(SCL_O),
   .SDA_O(SDA_O), .SCL_OE_O(SCL_OE_O), .SDA_OE_O(SDA_OE_O), .RX_READY_I(RX_READY_I),
   .RX_VALID_O(RX_VALID_O), .TX_REQ_O(TX_REQ_O), .BUSY_O(BUSY_O));
`default_nettype wire
